// ### rtl/sub_exec_defines.vh
`ifndef SUB_EXEC_DEFINES_VH
`define SUB_EXEC_DEFINES_VH

// Register map (byte addresses)
`define ADDR_CTRL        8'h00
`define ADDR_OPERAND     8'h04
`define ADDR_ACC         8'h08
`define ADDR_RESULT      8'h0C
`define ADDR_STATUS      8'h10
`define ADDR_WATCHDOG    8'h14
`define ADDR_WAKE        8'h18

// Control register fields
`define CTRL_OP_LSB      0
`define CTRL_OP_MSB      1
`define CTRL_DEST_BIT    2
`define CTRL_GO_BIT      3
`define CTRL_ADDR_LSB    8
`define CTRL_ADDR_MSB    14

// Operation codes
`define OP_LIT_SUB       2'h0
`define OP_REG_SUB       2'h1
`define OP_REG_SUB_B     2'h2
`define OP_SLEEP         2'h3

// Status register fields
`define ST_CARRY         0
`define ST_NIBBLE        1
`define ST_ZERO          2
`define ST_PD_N          3
`define ST_TO_N          4
`define ST_ASLEEP        5
`define ST_RESULT_DEST   6

// Reset values and watchdog prescaler width
`define STATUS_RESET     7'h18
`define WD_PRESCALE_W    8

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ### rtl/sub_alu.v
`timescale 1ns/10ps
`include "sub_exec_defines.vh"

module sub_alu (
	// Operands
	input  wire [7:0] minuend,
	input  wire [7:0] subtrahend,
	input  wire       borrow_in,
	// Results
	output wire [7:0] diff,
	output wire       carry_out,
	output wire       nibble_out,
	output wire       zero_out
);

	wire [8:0] full_sum;
	wire [4:0] low_sum;

	// Two's complement: add inverted subtrahend, carry in is not-borrow
	assign full_sum   = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, ~borrow_in};
	assign low_sum    = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, ~borrow_in};
	assign diff       = full_sum[7:0];
	assign carry_out  = full_sum[8];
	assign nibble_out = low_sum[4];
	assign zero_out   = (full_sum[7:0] == 8'h00);

endmodule // sub_alu

// ### rtl/subtract_and_sleep_exec.v
// How it works
// - Literal minus accumulator, result into accumulator
// - Carry/nibble carry set when subtrahend not larger
// - Register minus accumulator, destination bit selects target
// - Borrow variant also subtracts inverted carry
// - Sleep clears watchdog count and prescaler
// - Sleep clears powerdown bit, sets timeout bit
// - Sleep halts execution until wake-up
`timescale 1ns/10ps
`include "sub_exec_defines.vh"

module subtract_and_sleep_exec #(
	parameter PRESCALE_W = `WD_PRESCALE_W
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Core state
	output reg         osc_run_ff
);

	//////////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [15:0]           ctrl_ff;
	reg  [7:0]            operand_ff;
	reg  [7:0]            acc_ff;
	reg  [7:0]            result_ff;
	reg  [6:0]            status_ff;
	reg  [7:0]            watchdog_count_ff;
	reg  [PRESCALE_W-1:0] prescale_ff;
	reg                   aw_got_ff;
	reg                   w_got_ff;
	reg  [7:0]            aw_addr_ff;
	reg  [31:0]           w_data_ff;
	reg  [3:0]            w_strb_ff;
	reg                   exec_ff;

	wire [7:0]  alu_diff;
	wire        alu_carry;
	wire        alu_nibble;
	wire        alu_zero;
	wire [1:0]  op_sel;
	wire        dest_sel;
	wire [7:0]  minuend;
	wire        borrow;
	wire        go;
	wire        wr_fire;
	wire        asleep;

	assign op_sel   = ctrl_ff[`CTRL_OP_MSB:`CTRL_OP_LSB];
	assign dest_sel = ctrl_ff[`CTRL_DEST_BIT];
	assign asleep   = status_ff[`ST_ASLEEP];
	// Literal or register value both come through the operand register
	assign minuend  = operand_ff;
	assign borrow   = (op_sel == `OP_REG_SUB_B) ? ~status_ff[`ST_CARRY] : 1'b0;
	assign wr_fire  = aw_got_ff && w_got_ff && !s_axi_bvalid;
	// Go written while asleep is ignored: nothing runs without the oscillator
	assign go       = wr_fire && (aw_addr_ff == `ADDR_CTRL) && w_strb_ff[0]
	                  && w_data_ff[`CTRL_GO_BIT] && !asleep;

	sub_alu u_alu (
		.minuend    (minuend),
		.subtrahend (acc_ff),
		.borrow_in  (borrow),
		.diff       (alu_diff),
		.carry_out  (alu_carry),
		.nibble_out (alu_nibble),
		.zero_out   (alu_zero)
	);

	function [7:0] merge_byte;
		input [7:0]  old_val;
		input [31:0] data;
		input [3:0]  strb;
		begin
			merge_byte = strb[0] ? data[7:0] : old_val;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data latched in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff     <= 1'b1;
				aw_addr_ff    <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff     <= 1'b1;
				w_data_ff    <= s_axi_wdata;
				w_strb_ff    <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (aw_addr_ff)
					`ADDR_CTRL, `ADDR_OPERAND, `ADDR_ACC, `ADDR_RESULT,
					`ADDR_STATUS, `ADDR_WATCHDOG, `ADDR_WAKE: begin
						s_axi_bresp <= `RESP_OKAY;
					end
					default: begin
						s_axi_bresp <= `RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Execution and register state
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff           <= 16'h0000;
			operand_ff        <= 8'h00;
			acc_ff            <= 8'h00;
			result_ff         <= 8'h00;
			status_ff         <= `STATUS_RESET;
			watchdog_count_ff <= 8'h00;
			prescale_ff       <= {PRESCALE_W{1'b0}};
			osc_run_ff        <= 1'b1;
		end else begin
			// Free-running watchdog while awake
			if (osc_run_ff) begin
				prescale_ff <= prescale_ff + 1'b1;
				if (&prescale_ff)
					watchdog_count_ff <= watchdog_count_ff + 8'h01;
			end
			if (wr_fire) begin
				case (aw_addr_ff)
					`ADDR_CTRL: begin
						if (w_strb_ff[0])
							ctrl_ff[7:0] <= w_data_ff[7:0] & 8'h07;
						if (w_strb_ff[1])
							ctrl_ff[15:8] <= w_data_ff[15:8] & 8'h7F;
					end
					`ADDR_OPERAND: operand_ff <= merge_byte(operand_ff, w_data_ff, w_strb_ff);
					`ADDR_ACC:     acc_ff     <= merge_byte(acc_ff, w_data_ff, w_strb_ff);
					`ADDR_WAKE: begin
						// Wake-up source restarts the oscillator
						if (w_strb_ff[0] && w_data_ff[0]) begin
							osc_run_ff             <= 1'b1;
							status_ff[`ST_ASLEEP]  <= 1'b0;
						end
					end
					default: begin
						operand_ff <= operand_ff;
					end
				endcase
			end
			if (go) begin
				case (w_data_ff[`CTRL_OP_MSB:`CTRL_OP_LSB])
					`OP_SLEEP: begin
						watchdog_count_ff        <= 8'h00;
						prescale_ff              <= {PRESCALE_W{1'b0}};
						status_ff[`ST_PD_N]      <= 1'b0;
						status_ff[`ST_TO_N]      <= 1'b1;
						status_ff[`ST_ASLEEP]    <= 1'b1;
						osc_run_ff               <= 1'b0;
					end
					default: begin
						// Carry must survive until exec, it feeds the borrow
						status_ff <= status_ff;
					end
				endcase
			end
			// Subtract runs one cycle after go, using freshly stored ctrl
			if (exec_ff) begin
				status_ff[`ST_CARRY]  <= alu_carry;
				status_ff[`ST_NIBBLE] <= alu_nibble;
				status_ff[`ST_ZERO]   <= alu_zero;
				result_ff             <= alu_diff;
				if (op_sel == `OP_LIT_SUB || !dest_sel) begin
					acc_ff                     <= alu_diff;
					status_ff[`ST_RESULT_DEST] <= 1'b0;
				end else begin
					operand_ff                 <= alu_diff;
					status_ff[`ST_RESULT_DEST] <= 1'b1;
				end
			end
		end
	end

	// Delay go by one cycle so ctrl fields are settled
	always @(posedge aclk) begin
		if (!aresetn)
			exec_ff <= 1'b0;
		else
			exec_ff <= go && (w_data_ff[`CTRL_OP_MSB:`CTRL_OP_LSB] != `OP_SLEEP);
	end

	//////////////////////////////////////////////////////////////////////////////
	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_CTRL:     s_axi_rdata <= {16'h0000, ctrl_ff};
					`ADDR_OPERAND:  s_axi_rdata <= {24'h000000, operand_ff};
					`ADDR_ACC:      s_axi_rdata <= {24'h000000, acc_ff};
					`ADDR_RESULT:   s_axi_rdata <= {24'h000000, result_ff};
					`ADDR_STATUS:   s_axi_rdata <= {25'h0, status_ff};
					`ADDR_WATCHDOG: s_axi_rdata <= {24'h000000, watchdog_count_ff};
					`ADDR_WAKE:     s_axi_rdata <= 32'h00000000;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // subtract_and_sleep_exec

// ### sim/subtract_and_sleep_exec_props.sv
`timescale 1ns/10ps
module sub_exec_props (
	// Clock and reset
	input wire		aclk,
	input wire		aresetn,
	// Bus handshakes
	input wire		s_axi_awvalid,
	input wire		s_axi_awready,
	input wire		s_axi_wvalid,
	input wire		s_axi_wready,
	input wire		s_axi_bvalid,
	input wire		s_axi_bready,
	input wire		s_axi_arvalid,
	input wire		s_axi_arready,
	input wire		s_axi_rvalid,
	input wire		s_axi_rready,
	input wire [31:0]	s_axi_rdata,
	// Core state
	input wire		osc_run_ff
);
////////////////////////////////////////////////////////////////////////
// Run state may only move shortly after a data write is taken
reg	[7:0]	w_hist_ff;
always @(posedge aclk) begin
	if (!aresetn)
		w_hist_ff <= 8'h00;
	else
		w_hist_ff <= {w_hist_ff[6:0], s_axi_wvalid & s_axi_wready};
end
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////
property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped");
property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped");
property p_b_after; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
a_b_after: assert property (p_b_after) else $error("no write response");
property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
a_r_after: assert property (p_r_after) else $error("no read data");
property p_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]; endproperty
a_busy: assert property (p_busy) else $error("address taken twice");
property p_ready_back; s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready; endproperty
a_ready_back: assert property (p_ready_back) else $error("readies not restored");
property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
a_r_done: assert property (p_r_done) else $error("read data repeated");
property p_osc_cause; !$stable(osc_run_ff) |-> |w_hist_ff; endproperty
a_osc_cause: assert property (p_osc_cause) else $error("run state moved alone");
endmodule // sub_exec_props
bind subtract_and_sleep_exec sub_exec_props chk_i (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .osc_run_ff);

// ### sim/subtract_and_sleep_exec_test.sv
`timescale 1ns/10ps
`include "sub_exec_defines.vh"
module subtract_and_sleep_exec_test;
reg		aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, c;
reg		slow;
reg	[7:0]	s_axi_awaddr, s_axi_araddr, acc;
reg	[31:0]	s_axi_wdata, d;
reg	[3:0]	s_axi_wstrb;
reg	[2:0]	st;
reg	[1:0]	r;
wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_run_ff;
wire	[1:0]	s_axi_bresp, s_axi_rresp;
wire	[31:0]	s_axi_rdata;
integer		bad_count, check_count, n;
subtract_and_sleep_exec DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .osc_run_ff);
initial begin
	aclk = 1'b0;
	forever #20 aclk = ~aclk;
end
////////////////////////////////////////////////////////////////////////
task complete_run;
	begin
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
endtask
task chk(input [31:0] got, input [31:0] exp);
	begin
		check_count = check_count + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
endtask
task wr(input [7:0] a, input [31:0] v);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		r = 2'h3;
		for (n = 0; n < 50 && r === 2'h3; n = n + 1) begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end else if (s_axi_bvalid)
				s_axi_bready <= 1'b1;
		end
		if (r === 2'h3)
			chk(32'h0, 32'h1);
		if (r === 2'h3)
			complete_run;
	end
endtask
task rd(input [7:0] a);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		r = 2'h3;
		for (n = 0; n < 50 && r === 2'h3; n = n + 1) begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				r = s_axi_rresp;
				d = s_axi_rdata;
				s_axi_rready <= 1'b0;
			end else if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
		end
		if (r === 2'h3)
			chk(32'h0, 32'h1);
		if (r === 2'h3)
			complete_run;
	end
endtask
// Flags come from a 9-bit difference, so borrow out is bit 8
task run_op(input [1:0] op, input dest, input [7:0] f, input [7:0] w);
	reg	[8:0]	full;
	reg	[4:0]	low;
	reg		b, to_reg;
	begin
		b = (op == `OP_REG_SUB_B) & ~c;
		to_reg = dest & (op != `OP_LIT_SUB);
		full = {1'b0, f} - {1'b0, w} - b;
		low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - b;
		wr(`ADDR_OPERAND, {24'h0, f});
		wr(`ADDR_ACC, {24'h0, w});
		wr(`ADDR_CTRL, {17'h0, 7'h7F, 5'h01, dest, op});
		repeat (2) @(posedge aclk);
		c = ~full[8];
		st = {full[7:0] == 8'h00, ~low[4], c};
		acc = to_reg ? w : full[7:0];
		rd(to_reg ? `ADDR_OPERAND : `ADDR_ACC);
		chk(d, {24'h0, full[7:0]});
		rd(to_reg ? `ADDR_ACC : `ADDR_OPERAND);
		chk(d, {24'h0, to_reg ? w : f});
		rd(`ADDR_STATUS);
		chk(d[2:0], st);
	end
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	bad_count = 0;
	check_count = 0;
	c = 1'b0;
	slow = 1'b0;
	{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
	{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
	s_axi_wstrb = 4'hF;
	repeat (12) @(posedge aclk);
	aresetn <= 1'b1;
	rd(`ADDR_STATUS);
	chk(d, {25'h0, `STATUS_RESET});
	$display("test reset done");
	run_op(`OP_LIT_SUB, 1'b0, 8'h05, 8'h05);
	run_op(`OP_LIT_SUB, 1'b1, 8'hFF, 8'h01);
	run_op(`OP_LIT_SUB, 1'b0, 8'h00, 8'hFF);
	run_op(`OP_REG_SUB, 1'b0, 8'h10, 8'h01);
	run_op(`OP_REG_SUB, 1'b1, 8'h80, 8'h7F);
	run_op(`OP_REG_SUB_B, 1'b0, 8'h30, 8'h10);
	run_op(`OP_REG_SUB, 1'b0, 8'h00, 8'h01);
	run_op(`OP_REG_SUB_B, 1'b1, 8'h30, 8'h2F);
	run_op(`OP_REG_SUB, 1'b0, 8'h00, 8'h01);
	$display("test subtract done");
	// Late ready from here on, so the response holds get exercised
	slow = 1'b1;
	// Let the prescaler move before sleeping
	repeat (300) @(posedge aclk);
	wr(`ADDR_CTRL, {28'h0, 2'h2, `OP_SLEEP});
	repeat (2) @(posedge aclk);
	chk(osc_run_ff, 1'b0);
	rd(`ADDR_WATCHDOG);
	chk(d, 32'h0);
	rd(`ADDR_STATUS);
	chk(d[5:0], {3'h6, st});
	wr(`ADDR_CTRL, {28'h0, 2'h2, `OP_LIT_SUB});
	chk(r, `RESP_OKAY);
	repeat (2) @(posedge aclk);
	rd(`ADDR_ACC);
	chk(d, {24'h0, acc});
	wr(`ADDR_WAKE, 32'h1);
	for (n = 0; n < 20 && osc_run_ff !== 1'b1; n = n + 1)
		@(posedge aclk);
	chk(osc_run_ff, 1'b1);
	$display("test sleep done");
	rd(8'h1C);
	chk(r, `RESP_SLVERR);
	wr(8'h1C, 32'h5A);
	chk(r, `RESP_SLVERR);
	$display("test unmapped done");
	complete_run;
end
endmodule // subtract_and_sleep_exec_test
